// ===== common/tmr_pkg.sv
// Package for the dual timer/counter: register map, field positions, modes, carriers
package tmr_pkg;
    // Register indexes on the plain register port
    localparam logic [2:0] ADR_RUN = 3'h0;
    localparam logic [2:0] ADR_AUX = 3'h1;
    localparam logic [2:0] ADR_MODE = 3'h2;
    localparam logic [2:0] ADR_TL0 = 3'h3;
    localparam logic [2:0] ADR_TH0 = 3'h4;
    localparam logic [2:0] ADR_TL1 = 3'h5;
    localparam logic [2:0] ADR_TH1 = 3'h6;
    localparam logic [2:0] ADR_TL [2] = '{ADR_TL0, ADR_TL1};
    localparam logic [2:0] ADR_TH [2] = '{ADR_TH0, ADR_TH1};

    // Per channel bit positions, index 0 is T0, index 1 is T1
    localparam int FLAG_POS [2] = '{5, 7};
    localparam int RUN_POS [2] = '{4, 6};
    localparam int OE_POS [2] = '{1, 5};
    localparam int SCALE_POS [2] = '{0, 4};
    localparam int GATE_POS [2] = '{3, 7};
    localparam int FUNC_POS [2] = '{2, 6};
    localparam int MODE_LSB [2] = '{0, 4};

    localparam logic [7:0] RUN_MASK = 8'hF0;
    localparam logic [7:0] AUX_MASK = 8'h33;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

    localparam logic [1:0] MODE_RLD16 = 2'h0;
    localparam logic [1:0] MODE_FREE16 = 2'h1;
    localparam logic [1:0] MODE_RLD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Divide by 12 prescaler, counts 0 to 11
    localparam logic [3:0] PRESC_LAST = 4'hB;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmr_bus_s;

    typedef struct packed {
        logic [7:0] run_ctl;
        logic [7:0] aux;
        logic [7:0] mode;
        logic [1:0][7:0] tl;
        logic [1:0][7:0] th;
        logic [1:0][7:0] rld_lo;
        logic [1:0][7:0] rld_hi;
        logic [1:0][7:0] hbuf;
        logic [3:0] presc;
        logic [1:0] gs1;
        logic [1:0] gs2;
        logic [1:0] cs1;
        logic [1:0] cs2;
        logic [1:0] cprev;
        logic [1:0] cmp;
        logic [7:0] rdata;
    } tmr_state_s;
endpackage

// ===== hdl/tmr_dual.sv
// Dual 8/16-bit timer/counter with register port, gate and count pins
//
// Overview of operation
// - Hardware sets a channel's overflow flag, control bits 7 and 5, on overflow.
// - Interrupt response or a software zero write clears the overflow flag.
// - Run bits 6 and 4 stop the channel at zero, start it at one.
// - Auxiliary bits 7, 6, 3, 2 read zero and ignore writes.
// - Auxiliary bits 5 and 1 enable the comparison output per channel.
// - Auxiliary bits 4 and 0 pick oscillator divided by 12 or undivided.
// - Gate bit set: count only while run bit set and gate pin high.
// - Function bit selects internal timer or external event counting.
// - Mode field: 16-bit reload, 16-bit plain, 8-bit auto reload, split.
// - Split mode: T0 high byte borrows T1 run bit and flag; T1 runs ungated without a run bit unless T1 is in split mode too.
// - Each channel has a read/write low data byte.
// - Each channel has a read/write high data byte.
// - Reload mode: high byte write buffered until the next low byte write.
// - Reload mode: running writes change reload only; stopped writes change both.
// - 8-bit reload: low byte wraps, flag set, high byte copied into low.
// - External counting increments on each falling edge of the count pin.
`timescale 1ns/10ps
module tmr_dual (
    input wire logic clk,
    input wire logic srst,
    input wire tmr_pkg::tmr_bus_s bus,
    output logic [7:0] rdata,
    input wire logic [1:0] gate_input_pin,
    input wire logic [1:0] count_pin,
    input wire logic [1:0] intr_ack,
    output logic [1:0] overflow_flag,
    output logic [1:0] cmp_pin
);
    import tmr_pkg::*;

    tmr_state_s st_ff;
    tmr_state_s nxt_st;
    logic tick12;
    logic split;
    logic [1:0] fall;
    logic [1:0] run_eff;
    logic [1:0] inc;
    logic [1:0] ov;
    logic [1:0] set;
    logic ov_h;
    logic [1:0][1:0] md;
    logic [15:0] word;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        word = 16'h0000;
        ov = 2'b00;
        ov_h = 1'b0;
        inc = 2'b00;
        run_eff = 2'b00;
        md[0] = st_ff.mode[MODE_LSB[0] +: 2];
        md[1] = st_ff.mode[MODE_LSB[1] +: 2];
        split = (md[0] == MODE_SPLIT);
        // Pins pass two flops; edge detect compares the second stage with its copy one cycle older
        nxt_st.gs1 = gate_input_pin;
        nxt_st.gs2 = st_ff.gs1;
        nxt_st.cs1 = count_pin;
        nxt_st.cs2 = st_ff.cs1;
        nxt_st.cprev = st_ff.cs2;
        fall = st_ff.cprev & ~st_ff.cs2;
        tick12 = (st_ff.presc == PRESC_LAST);
        nxt_st.presc = tick12 ? 4'h0 : 4'(st_ff.presc + 4'h1);

        for (int c = 0; c < 2; c++) begin
            if (c == 1 && split) begin
                // T1 lost its run bit: timer only, no gate, runs unless in split itself
                run_eff[c] = (md[c] != MODE_SPLIT);
                inc[c] = run_eff[c] & (st_ff.aux[SCALE_POS[c]] | tick12);
            end else begin
                run_eff[c] = st_ff.run_ctl[RUN_POS[c]];
                inc[c] = run_eff[c]
                    & (!st_ff.mode[GATE_POS[c]] | st_ff.gs2[c])
                    & (st_ff.mode[FUNC_POS[c]] ? fall[c]
                        : (st_ff.aux[SCALE_POS[c]] | tick12))
                    & !(c == 1 && md[c] == MODE_SPLIT);
            end
            word = {st_ff.th[c], st_ff.tl[c]};
            if (inc[c]) begin
                case (md[c])
                    MODE_RLD16: begin
                        ov[c] = (word == WORD_MAX);
                        if (ov[c]) begin
                            nxt_st.th[c] = st_ff.rld_hi[c];
                            nxt_st.tl[c] = st_ff.rld_lo[c];
                        end else begin
                            {nxt_st.th[c], nxt_st.tl[c]} = 16'(word + 16'h0001);
                        end
                    end
                    MODE_FREE16: begin
                        ov[c] = (word == WORD_MAX);
                        {nxt_st.th[c], nxt_st.tl[c]} = 16'(word + 16'h0001);
                    end
                    MODE_RLD8: begin
                        ov[c] = (st_ff.tl[c] == BYTE_MAX);
                        nxt_st.tl[c] = ov[c] ? st_ff.th[c] : 8'(st_ff.tl[c] + 8'h01);
                    end
                    default: begin
                        ov[c] = (st_ff.tl[c] == BYTE_MAX);
                        nxt_st.tl[c] = 8'(st_ff.tl[c] + 8'h01);
                    end
                endcase
            end
        end

        // Split: T0 high byte is a timer run by T1's run bit
        if (split && st_ff.run_ctl[RUN_POS[1]] && (st_ff.aux[SCALE_POS[0]] || tick12)) begin
            ov_h = (st_ff.th[0] == BYTE_MAX);
            nxt_st.th[0] = 8'(st_ff.th[0] + 8'h01);
        end

        ////////////////////////////////////////////////////////////////////
        // Software writes win over the count in the same cycle
        if (bus.wr) begin
            case (bus.addr)
                ADR_RUN: nxt_st.run_ctl = bus.wdata & RUN_MASK;
                ADR_AUX: nxt_st.aux = bus.wdata & AUX_MASK;
                ADR_MODE: nxt_st.mode = bus.wdata;
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        if (bus.addr == ADR_TL[c]) begin
                            if (md[c] == MODE_RLD16) begin
                                nxt_st.rld_lo[c] = bus.wdata;
                                nxt_st.rld_hi[c] = st_ff.hbuf[c];
                                if (!run_eff[c]) begin
                                    nxt_st.tl[c] = bus.wdata;
                                    nxt_st.th[c] = st_ff.hbuf[c];
                                end
                            end else begin
                                nxt_st.tl[c] = bus.wdata;
                            end
                        end
                        if (bus.addr == ADR_TH[c]) begin
                            // Half-written reload word would corrupt the period
                            if (md[c] == MODE_RLD16 && !(c == 0 && split)) begin
                                nxt_st.hbuf[c] = bus.wdata;
                            end else begin
                                nxt_st.th[c] = bus.wdata;
                            end
                        end
                    end
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Set wins over both kinds of clear
        set[0] = ov[0];
        set[1] = split ? ov_h : ov[1];
        for (int c = 0; c < 2; c++) begin
            nxt_st.run_ctl[FLAG_POS[c]] = (nxt_st.run_ctl[FLAG_POS[c]] & ~intr_ack[c]) | set[c];
            if (ov[c] && st_ff.aux[OE_POS[c]]) begin
                nxt_st.cmp[c] = ~st_ff.cmp[c];
            end
        end

        nxt_st.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                ADR_RUN: nxt_st.rdata = st_ff.run_ctl;
                ADR_AUX: nxt_st.rdata = st_ff.aux;
                ADR_MODE: nxt_st.rdata = st_ff.mode;
                ADR_TL0: nxt_st.rdata = st_ff.tl[0];
                ADR_TH0: nxt_st.rdata = st_ff.th[0];
                ADR_TL1: nxt_st.rdata = st_ff.tl[1];
                ADR_TH1: nxt_st.rdata = st_ff.th[1];
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            nxt_st_reset: st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign cmp_pin = st_ff.cmp;
    assign overflow_flag = {st_ff.run_ctl[FLAG_POS[1]], st_ff.run_ctl[FLAG_POS[0]]};

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_flag_set;
        ov[0] |=> overflow_flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on overflow");

    property p_ack_clr;
        overflow_flag[1] && intr_ack[1] && !set[1] && !bus.wr |=> !overflow_flag[1];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack did not clear flag");

    property p_stopped;
        !st_ff.run_ctl[RUN_POS[0]] && !bus.wr && !split |=> $stable(st_ff.tl[0]);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");

    property p_aux_rsv;
        bus.rd && bus.addr == ADR_AUX |=> (rdata & ~AUX_MASK) == 8'h00;
    endproperty
    a_aux_rsv: assert property (p_aux_rsv) else $error("reserved bits nonzero");

    property p_reset;
        $past(srst) |-> st_ff.run_ctl == RST_BYTE && st_ff.mode == RST_BYTE && st_ff.aux == RST_BYTE;
    endproperty
    a_reset: assert property (p_reset) else $error("registers not cleared by reset");

    property p_th_buffered;
        bus.wr && bus.addr == ADR_TH1 && md[1] == MODE_RLD16 && !inc[1] |=> $stable(st_ff.th[1]);
    endproperty
    a_th_buffered: assert property (p_th_buffered) else $error("high byte write not buffered");

    property p_stopped_load;
        bus.wr && bus.addr == ADR_TL0 && md[0] == MODE_RLD16 && !run_eff[0]
            |=> {st_ff.th[0], st_ff.tl[0]} == {$past(st_ff.hbuf[0]), $past(bus.wdata)};
    endproperty
    a_stopped_load: assert property (p_stopped_load) else $error("stopped write missed counter");

    property p_rld8;
        ov[0] && md[0] == MODE_RLD8 && !bus.wr |=> st_ff.tl[0] == st_ff.th[0] && overflow_flag[0];
    endproperty
    a_rld8: assert property (p_rld8) else $error("8-bit reload wrong");

    property p_toggle;
        ov[1] && st_ff.aux[OE_POS[1]] |=> cmp_pin[1] != $past(cmp_pin[1]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("compare output did not toggle");

    property p_ext_edge;
        st_ff.mode[FUNC_POS[0]] && inc[0] |-> $past(st_ff.cs2[0]) && !st_ff.cs2[0];
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("external count without falling edge");

    // Flag, ack, reload and output checks mirrored on the other channel, split borrowing, output enable, gate
    property p_flag_set_t1;
        !split && ov[1] |=> overflow_flag[1];
    endproperty
    a_flag_set_t1: assert property (p_flag_set_t1) else $error("second flag not set on overflow");

    property p_split_flag;
        split && ov_h |=> overflow_flag[1];
    endproperty
    a_split_flag: assert property (p_split_flag) else $error("split high byte missed second flag");

    property p_ack_clr0;
        overflow_flag[0] && intr_ack[0] && !set[0] && !bus.wr |=> !overflow_flag[0];
    endproperty
    a_ack_clr0: assert property (p_ack_clr0) else $error("ack did not clear first flag");

    property p_rld8_t1;
        ov[1] && md[1] == MODE_RLD8 && !bus.wr |=> st_ff.tl[1] == st_ff.th[1];
    endproperty
    a_rld8_t1: assert property (p_rld8_t1) else $error("second channel 8-bit reload wrong");

    property p_toggle0;
        ov[0] && st_ff.aux[OE_POS[0]] |=> cmp_pin[0] != $past(cmp_pin[0]);
    endproperty
    a_toggle0: assert property (p_toggle0) else $error("first compare output did not toggle");

    property p_no_oe;
        !st_ff.aux[OE_POS[0]] |=> $stable(cmp_pin[0]);
    endproperty
    a_no_oe: assert property (p_no_oe) else $error("disabled compare output moved");

    property p_t1_closed;
        md[1] == MODE_SPLIT && !bus.wr |=> $stable(st_ff.tl[1]) && $stable(st_ff.th[1]);
    endproperty
    a_t1_closed: assert property (p_t1_closed) else $error("closed second channel moved");

    property p_gate_hold;
        st_ff.mode[GATE_POS[0]] && !st_ff.gs2[0] && !bus.wr |=> $stable(st_ff.tl[0]);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("counted with gate pin low");

    // Prescaled and pin-driven counting must hold still between their events
    property p_scale12;
        !st_ff.aux[SCALE_POS[0]] && !st_ff.mode[FUNC_POS[0]] && !tick12 |-> !inc[0];
    endproperty
    a_scale12: assert property (p_scale12) else $error("divided timer counted off its tick");

    property p_ext_only;
        st_ff.mode[FUNC_POS[0]] && !fall[0] |-> !inc[0];
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("event counter counted without edge");

    property p_rd_idle;
        !bus.rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    c_ovf16: cover property (ov[0] && md[0] == MODE_FREE16);
    c_split: cover property (ov_h && split);
    c_ack: cover property (overflow_flag[0] ##1 !overflow_flag[0]);
    c_rld8: cover property (ov[1] && md[1] == MODE_RLD8);
    c_gate: cover property (st_ff.mode[GATE_POS[0]] && inc[0]);
endmodule

// ===== testbench/test_dual_timer_counter_regs.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/10ps
module test_dual_timer_counter_regs;
    import tmr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    tmr_bus_s bus = '0;
    logic [7:0] rdata, v;
    logic [1:0] gate_lvl = 2'h0, pulse_go = 2'h0, intr_ack = 2'h0;
    logic [1:0] gate_input_pin, count_pin, overflow_flag, cmp_pin;
    int err_count = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    tmr_dual i_tmr_dual (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .gate_input_pin(gate_input_pin),
        .count_pin(count_pin), .intr_ack(intr_ack), .overflow_flag(overflow_flag), .cmp_pin(cmp_pin));
    tmr_far_pins i_tmr_far_pins (.clk(clk), .gate_lvl(gate_lvl), .pulse_go(pulse_go),
        .gate_input_pin(gate_input_pin), .count_pin(count_pin));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_flag(input int ch);
        int k;
        k = 0;
        #1;
        while (overflow_flag[ch] !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 3000) begin
            err_count++;
            $display("Error overflow wait expected 1 seen 0");
            give_verdict;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            check("reset reg", v, RST_BYTE);
        end
        $display("Test reset done");
        wr(ADR_AUX, 8'hFF);
        rd(ADR_AUX);
        check("aux", v, 8'h33);
        wr(ADR_RUN, 8'h0F);
        rd(ADR_RUN);
        check("run ctl", v, 8'h00);
        wr(ADR_TH0, 8'h05);
        wr(ADR_TL0, 8'h08);
        rd(ADR_TH0);
        check("TH0", v, 8'h05);
        rd(ADR_TL0);
        check("TL0", v, 8'h08);
        wr(ADR_TH0, 8'h06);
        rd(ADR_TH0);
        check("TH0 buffered", v, 8'h05);
        $display("Test registers done");
        wr(ADR_TH0, 8'hFF);
        wr(ADR_TL0, 8'hF0);
        wr(ADR_AUX, 8'h03);
        wr(ADR_RUN, 8'h10);
        wait_flag(0);
        check("cmp0", {7'h0, cmp_pin[0]}, 8'h01);
        wr(ADR_TH0, 8'h12);
        wr(ADR_TL0, 8'h34);
        rd(ADR_TH0);
        check("TH0 running write", v, 8'hFF);
        @(posedge clk);
        intr_ack <= 2'h1;
        @(posedge clk);
        intr_ack <= 2'h0;
        #1 check("flag0 ack", {7'h0, overflow_flag[0]}, 8'h00);
        wait_flag(0);
        wr(ADR_RUN, 8'h00);
        rd(ADR_TH0);
        check("TH0 reload", v, 8'h12);
        check("cmp0 again", {7'h0, cmp_pin[0]}, 8'h00);
        rd(ADR_RUN);
        check("flag sw clear", v, 8'h00);
        $display("Test reload done");
        wr(ADR_MODE, 8'h20);
        wr(ADR_TH1, 8'hF0);
        wr(ADR_TL1, 8'hFC);
        wr(ADR_AUX, 8'h30);
        wr(ADR_RUN, 8'h40);
        wait_flag(1);
        check("cmp1", {7'h0, cmp_pin[1]}, 8'h01);
        @(posedge clk);
        intr_ack <= 2'h2;
        @(posedge clk);
        intr_ack <= 2'h0;
        #1 check("flag1 ack", {7'h0, overflow_flag[1]}, 8'h00);
        wr(ADR_RUN, 8'h00);
        rd(ADR_TH1);
        check("TH1 kept", v, 8'hF0);
        rd(ADR_TL1);
        check("TL1 reloaded", {4'h0, v[7:4]}, 8'h0F);
        $display("Test eight bit done");
        wr(ADR_MODE, 8'h09);
        wr(ADR_AUX, 8'h11);
        wr(ADR_TL0, 8'h00);
        wr(ADR_TH0, 8'h00);
        wr(ADR_RUN, 8'h10);
        repeat (30) @(posedge clk);
        rd(ADR_TL0);
        check("gated", v, 8'h00);
        @(posedge clk) gate_lvl <= 2'h1;
        repeat (20) @(posedge clk);
        rd(ADR_TL0);
        check("gate open", {7'h0, v >= 8'h0A}, 8'h01);
        wr(ADR_MODE, 8'h05);
        wr(ADR_RUN, 8'h00);
        wr(ADR_TL0, 8'h00);
        wr(ADR_RUN, 8'h10);
        repeat (3) begin
            @(posedge clk);
            pulse_go <= 2'h1;
            @(posedge clk);
            pulse_go <= 2'h0;
            repeat (10) @(posedge clk);
        end
        rd(ADR_TL0);
        check("ext count", v, 8'h03);
        wr(ADR_AUX, 8'h00);
        wr(ADR_MODE, 8'h01);
        wr(ADR_TL0, 8'h00);
        repeat (120) @(posedge clk);
        wr(ADR_RUN, 8'h00);
        rd(ADR_TL0);
        check("div12", {7'h0, v >= 8'h09 && v <= 8'h0B}, 8'h01);
        $display("Test counting done");
        wr(ADR_MODE, 8'h33);
        wr(ADR_TH0, 8'hFE);
        wr(ADR_AUX, 8'h01);
        wr(ADR_RUN, 8'h40);
        wait_flag(1);
        check("split flag0", {7'h0, overflow_flag[0]}, 8'h00);
        $display("Test split done");
        give_verdict;
    end
endmodule

// ===== testbench/tmr_far_pins.sv
// Far side model: gate pin levels and falling-edge count pulses
`timescale 1ns/10ps
module tmr_far_pins (
    input wire logic clk,
    input wire logic [1:0] gate_lvl,
    input wire logic [1:0] pulse_go,
    output logic [1:0] gate_input_pin,
    output logic [1:0] count_pin
);
    logic [1:0][2:0] low_cnt = '0;
    assign gate_input_pin = gate_lvl;
    // Low phase of 4 clocks, long enough for the two-flop sync
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (pulse_go[i]) begin
                low_cnt[i] <= 3'h4;
            end else if (low_cnt[i] != 3'h0) begin
                low_cnt[i] <= low_cnt[i] - 3'h1;
            end
        end
    end
    assign count_pin = {low_cnt[1] == 3'h0, low_cnt[0] == 3'h0};
endmodule
